// file: src/ars_pkg.sv
/*
  Constants, types and helpers shared by the asynchronous reset sequencer.
  Assumes one core clock at 100 MHz and pins that are already synchronous.
*/
// How it works
// - Both pins low enters asynchronous reset.
// - Reset state: reset outputs low, buses released.
// - Entry detection works without a clock.
// - Internal boot waits for flash initialization.
// - External boot releases after 3..8 half-clocks.
// - Early flash reads return FFFFh, then 009Bh.
// - Flash initialization needs no system clock.
// - Sense falling during held reset goes asynchronous.
// - Release latches configuration, strobes inactive.
// - Fetch starts at address zero, segment zero.
// - Reject short spikes, accept long pulses.
`default_nettype none
package ars_pkg;

  localparam int CLK_PERIOD_NS    = 10;
  localparam int FILTER_REJECT_NS = 50;
  // A least time, so the cycle count rounds up.
  localparam int FILTER_CYC =
    (FILTER_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CLK_PER_CLK = 2;
  localparam int EXT_HALF_MIN     = 3;
  localparam int EXT_HALF_MAX     = 8;
  localparam int FLASH_EARLY_CYC  = 16;

  localparam logic [15:0] FLASH_BLANK_WORD = 16'hFFFF;
  localparam logic [15:0] FLASH_INIT_WORD  = 16'h009B;
  localparam logic [23:0] BOOT_ADDR        = 24'h000000;
  localparam logic [7:0]  BOOT_SEGMENT     = 8'h00;
  localparam logic [15:0] CFG_RESET        = 16'hFFFF;
  localparam int          CLKOPT_LSB       = 13;
  localparam int          CLKOPT_W         = 3;

  typedef enum logic [2:0] {
    ST_HOLD, ST_FLASH_WAIT, ST_EXT_WAIT, ST_SYNC, ST_RUN
  } ars_state_t;

  typedef struct packed {
    logic bus_drive_en;
    logic io_drive_en;
    logic cfg_pullup_en;
    logic hold_cancel;
    logic bus_abort;
  } ars_pad_ctl_t;

  typedef struct packed {
    logic ale;
    logic read_strobe_n;
    logic write_strobe_n;
  } ars_strobe_t;

  localparam ars_pad_ctl_t PAD_RESET = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam ars_pad_ctl_t PAD_RUN   = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  localparam ars_strobe_t  STROBE_IDLE = '{1'b0, 1'b1, 1'b1};

  // Release delay in core cycles for a clock option; two half-clocks each.
  function automatic logic [2:0] ext_release_cyc(
    input logic [CLKOPT_W-1:0] opt);
    int halves;
    halves = EXT_HALF_MIN + int'(opt);
    if (halves > EXT_HALF_MAX) begin
      halves = EXT_HALF_MAX;
    end
    return 3'((halves + HALF_CLK_PER_CLK - 1) / HALF_CLK_PER_CLK);
  endfunction : ext_release_cyc

endpackage : ars_pkg
`default_nettype wire

// file: src/ars_rel_sync.sv
/*
  Two-flop reset release synchroniser with asynchronous assertion.
  Assumes async_clr may change at any time, clock running or not.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_rel_sync (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic async_clr,
  input  wire logic rel_req,
  output var  logic rel_out
);

  logic stage1_q;

  // Assertion is immediate; release crosses two flops to avoid metastability.
  always_ff @(posedge core_clk or posedge async_clr) begin
    if (async_clr) begin
      stage1_q <= 1'b0;
      rel_out  <= 1'b0;
    end else if (!rst_b) begin
      stage1_q <= 1'b0;
      rel_out  <= 1'b0;
    end else begin
      stage1_q <= rel_req;
      rel_out  <= stage1_q;
    end
  end

endmodule : ars_rel_sync
`default_nettype wire

// file: src/ars_sequencer.sv
/*
  Asynchronous reset sequencer: enters reset from the pins with no clock,
  sequences release through flash initialization or a short external-boot
  delay, latches start-up configuration and launches the first fetch.
  Assumes the flash macro runs its own oscillator and reports completion
  as a level synchronous to core_clk, and that the reset and sense pins
  come through the pad filter already.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_sequencer
  import ars_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         reset_in_n,
  input  wire logic         power_down_sense,
  input  wire logic         external_access_select_n,
  input  wire logic [15:0]  config_port_pins,
  input  wire logic         flash_init_done,
  input  wire logic         flash_rd,
  input  wire logic [15:0]  flash_rdata,
  input  wire ars_strobe_t  cpu_strobe,
  output var  logic         reset_out_n,
  output var  logic         core_reset_n,
  output var  logic         async_taken,
  output var  ars_pad_ctl_t pad_ctl,
  output var  ars_strobe_t  bus_strobe,
  output var  logic [15:0]  sys_config,
  output var  logic [2:0]   clock_option_pins,
  output var  logic         flash_init_start,
  output var  logic [15:0]  flash_rd_data,
  output var  logic         fetch_go,
  output var  logic [23:0]  fetch_addr,
  output var  logic [7:0]   fetch_segment
);

  ars_state_t  state_q;
  logic        async_hit;
  logic        rin_filt_q;
  logic [2:0]  filt_cnt_q;
  logic [2:0]  ext_cnt_q;
  logic [2:0]  ext_cyc_q;
  logic [4:0]  early_cnt_q;
  logic        flash_busy_q;
  logic        rel_req;
  logic        core_rel;
  logic        core_rel_d1_q;
  logic        leave_hold;

  // Pure gating, so entry needs no clock edge at all.
  assign async_hit = !reset_in_n && !power_down_sense;

  // Hold may be left only on a filtered high on the reset pin.
  assign leave_hold = (state_q == ST_HOLD) && rin_filt_q;
  assign rel_req    = (state_q == ST_SYNC) || (state_q == ST_RUN);

  // spike filter counter
  // The pin must disagree with the filtered level for FILTER_CYC cycles.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      rin_filt_q <= 1'b0;
      filt_cnt_q <= 3'h0;
    end else if (!rst_b) begin
      rin_filt_q <= 1'b0;
      filt_cnt_q <= 3'h0;
    end else if (reset_in_n == rin_filt_q) begin
      filt_cnt_q <= 3'h0;
    end else if (filt_cnt_q == 3'(FILTER_CYC - 1)) begin
      rin_filt_q <= reset_in_n;
      filt_cnt_q <= 3'h0;
    end else begin
      filt_cnt_q <= filt_cnt_q + 3'h1;
    end
  end

  // sticky asynchronous mark
  // Once taken it stays until the reset pin is high again, even if sense
  // rises meanwhile; the reset then completes as asynchronous.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      async_taken <= 1'b1;
    end else if (!rst_b) begin
      async_taken <= 1'b0;
    end else if (rin_filt_q) begin
      async_taken <= 1'b0;
    end
  end

  // Main sequence; every entry path lands in hold with a constant.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      state_q <= ST_HOLD;
    end else if (!rst_b) begin
      state_q <= ST_HOLD;
    end else begin
      unique case (state_q)
        ST_HOLD: begin
          if (rin_filt_q) begin
            state_q <= external_access_select_n ? ST_FLASH_WAIT
                                                : ST_EXT_WAIT;
          end
        end
        ST_FLASH_WAIT: begin
          // Flash finishes on its own oscillator.
          if (flash_init_done) begin
            state_q <= ST_SYNC;
          end
        end
        ST_EXT_WAIT: begin
          if (ext_cnt_q >= ext_cyc_q) begin
            state_q <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (core_rel) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // half-clock delay count
  // The option comes from the pins being latched in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_b || state_q == ST_HOLD) begin
      ext_cnt_q <= 3'h1;
      ext_cyc_q <= ext_release_cyc(
        config_port_pins[CLKOPT_LSB +: CLKOPT_W]);
    end else if (state_q == ST_EXT_WAIT) begin
      ext_cnt_q <= ext_cnt_q + 3'h1;
    end
  end

  // latch configuration on release
  // Pins read as pulled high while the hold lasts.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      sys_config <= CFG_RESET;
    end else if (!rst_b) begin
      sys_config <= CFG_RESET;
    end else if (leave_hold) begin
      sys_config <= config_port_pins;
    end
  end

  assign clock_option_pins = sys_config[CLKOPT_LSB +: CLKOPT_W];

  ars_rel_sync u_rel_sync (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .async_clr (async_hit),
    .rel_req   (rel_req),
    .rel_out   (core_rel)
  );

  assign core_reset_n = core_rel;

  // reset default pads
  // Buses stay released until the core leaves reset, so no driver fights
  // the configuration pull-ups while the pins are being sampled.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      reset_out_n <= 1'b0;
      pad_ctl     <= PAD_RESET;
    end else if (!rst_b || !core_rel) begin
      reset_out_n <= 1'b0;
      pad_ctl     <= PAD_RESET;
    end else begin
      reset_out_n <= 1'b1;
      pad_ctl     <= PAD_RUN;
    end
  end

  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      bus_strobe <= STROBE_IDLE;
    end else if (!rst_b || !core_rel) begin
      bus_strobe <= STROBE_IDLE;
    end else begin
      bus_strobe <= cpu_strobe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      core_rel_d1_q <= 1'b0;
      fetch_go      <= 1'b0;
    end else begin
      core_rel_d1_q <= core_rel;
      fetch_go      <= core_rel && !core_rel_d1_q;
    end
  end

  assign fetch_addr    = BOOT_ADDR;
  assign fetch_segment = BOOT_SEGMENT;

  // Flash initialization is kicked on every exit from hold, for both boot
  // modes, because data in flash is wanted later even for external boot.
  always_ff @(posedge core_clk or posedge async_hit) begin
    if (async_hit) begin
      flash_init_start <= 1'b0;
      flash_busy_q     <= 1'b1;
      early_cnt_q      <= 5'h00;
    end else if (!rst_b) begin
      flash_init_start <= 1'b0;
      flash_busy_q     <= 1'b1;
      early_cnt_q      <= 5'h00;
    end else begin
      flash_init_start <= leave_hold;
      if (flash_init_done && !leave_hold) begin
        flash_busy_q <= 1'b0;
      end
      if (!flash_busy_q) begin
        early_cnt_q <= 5'h00;
      end else if (state_q != ST_HOLD &&
                   early_cnt_q != 5'(FLASH_EARLY_CYC)) begin
        early_cnt_q <= early_cnt_q + 5'h01;
      end
    end
  end

  // blank words while busy
  // Software must not read early; an early read yields blank or trap word.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flash_rd_data <= 16'h0000;
    end else if (flash_rd) begin
      if (!flash_busy_q) begin
        flash_rd_data <= flash_rdata;
      end else if (early_cnt_q < 5'(FLASH_EARLY_CYC)) begin
        flash_rd_data <= FLASH_BLANK_WORD;
      end else begin
        flash_rd_data <= FLASH_INIT_WORD;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_spike;
    rin_filt_q && power_down_sense && !reset_in_n ##1 reset_in_n;
  endsequence

  sequence s_ext_exit;
    leave_hold && !external_access_select_n;
  endsequence

  property p_async_entry;
    async_hit |-> !core_reset_n && !reset_out_n && state_q == ST_HOLD;
  endproperty
  a_async_entry: assert property (p_async_entry)
    else $error("Core left running with both pins low.");

  property p_pads_reset;
    async_hit |-> pad_ctl == PAD_RESET;
  endproperty
  a_pads_reset: assert property (p_pads_reset)
    else $error("Pads not in reset default state.");

  property p_flash_gate;
    state_q == ST_FLASH_WAIT && !flash_init_done |=> ##1 !core_reset_n;
  endproperty
  a_flash_gate: assert property (p_flash_gate)
    else $error("Core released before flash initialization.");

  property p_ext_release;
    s_ext_exit ##1 (!async_hit)[*8] |-> core_reset_n;
  endproperty
  a_ext_release: assert property (p_ext_release)
    else $error("External boot release too slow.");

  property p_early_read;
    flash_rd && flash_busy_q |=>
      flash_rd_data == FLASH_BLANK_WORD || flash_rd_data == FLASH_INIT_WORD;
  endproperty
  a_early_read: assert property (p_early_read)
    else $error("Early flash read returned live data.");

  property p_sticky_async;
    async_taken && !reset_in_n |=> async_taken;
  endproperty
  a_sticky_async: assert property (p_sticky_async)
    else $error("Asynchronous mark lost while reset held.");

  property p_config_latch;
    leave_hold |=> sys_config == $past(config_port_pins);
  endproperty
  a_config_latch: assert property (p_config_latch)
    else $error("Configuration not latched on release.");

  property p_strobe_idle;
    !core_reset_n |=> bus_strobe == STROBE_IDLE;
  endproperty
  a_strobe_idle: assert property (p_strobe_idle)
    else $error("Strobe active during reset.");

  property p_fetch_start;
    $rose(core_reset_n) |=> fetch_go && fetch_addr == BOOT_ADDR;
  endproperty
  a_fetch_start: assert property (p_fetch_start)
    else $error("First fetch not launched at address zero.");

  property p_spike_reject;
    s_spike |-> rin_filt_q;
  endproperty
  a_spike_reject: assert property (p_spike_reject)
    else $error("One-cycle spike passed the filter.");

  property p_sync_release;
    $rose(core_reset_n) |-> $past(rel_req, 2) && !async_hit;
  endproperty
  a_sync_release: assert property (p_sync_release)
    else $error("Release not through two synchroniser flops.");

endmodule : ars_sequencer
`default_nettype wire

// file: testbench/ars_ext_rst_model.sv
/*
  Model of the board circuitry that drives the reset and sense pins.
  Assumes the bench calls its tasks; pins move after falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module ars_ext_rst_model (
  input  wire logic core_clk,
  output var  logic reset_in_n,
  output var  logic power_down_sense
);
  // Least low time of a hardware pulse: 500 ns plus one cycle.
  localparam int PULSE_MIN_CYC = 51;
  // Power-on hold, shortened from milliseconds to keep the run brief.
  localparam int PWR_HOLD_CYC  = 200;

  initial begin
    reset_in_n       = 1'b0;
    power_down_sense = 1'b0;
  end

  // Set both pins after a falling edge, then hold them n cycles.
  task automatic drive(input logic r, input logic s, input int n);
    @(negedge core_clk);
    reset_in_n       = r;
    power_down_sense = s;
    repeat (n) @(negedge core_clk);
  endtask : drive

  task automatic power_on();
    drive(1'b0, 1'b0, PWR_HOLD_CYC);
  endtask : power_on

  task automatic hw_pulse();
    drive(1'b0, 1'b0, PULSE_MIN_CYC);
  endtask : hw_pulse

  // Pull both pins low by delay alone, for use with the clock stopped.
  task automatic clockless();
    #12;
    reset_in_n       = 1'b0;
    power_down_sense = 1'b0;
  endtask : clockless

endmodule : ars_ext_rst_model
`default_nettype wire

// file: testbench/testbench.sv
/*
  Self-checking bench for the asynchronous reset sequencer.
  Assumes the board model drives the pins and the bench the rest.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ars_pkg::*;
  logic         clk_raw, clk_run, core_clk, rst_b, xsel_n, fdone, frd;
  logic         rin_n, sense, reset_out_n, core_reset_n, async_taken;
  logic         flash_init_start, fetch_go;
  logic [15:0]  cfg, frdat, sys_config, flash_rd_data;
  logic [2:0]   clock_option_pins;
  logic [23:0]  fetch_addr;
  logic [7:0]   fetch_segment;
  ars_strobe_t  cstb, bus_strobe;
  ars_pad_ctl_t pad_ctl;
  int           fails, n_tests, cyc;

  ars_ext_rst_model m (.core_clk(core_clk), .reset_in_n(rin_n),
    .power_down_sense(sense));

  ars_sequencer dut (.core_clk(core_clk), .rst_b(rst_b),
    .reset_in_n(rin_n), .power_down_sense(sense),
    .external_access_select_n(xsel_n), .config_port_pins(cfg),
    .flash_init_done(fdone), .flash_rd(frd), .flash_rdata(frdat),
    .cpu_strobe(cstb), .reset_out_n(reset_out_n),
    .core_reset_n(core_reset_n), .async_taken(async_taken),
    .pad_ctl(pad_ctl), .bus_strobe(bus_strobe), .sys_config(sys_config),
    .clock_option_pins(clock_option_pins),
    .flash_init_start(flash_init_start), .flash_rd_data(flash_rd_data),
    .fetch_go(fetch_go), .fetch_addr(fetch_addr),
    .fetch_segment(fetch_segment));

  // Free clock, gated so the entry path can be tried with no clock.
  initial begin
    clk_raw = 1'b0;
    forever #5 clk_raw = ~clk_raw;
  end
  assign core_clk = clk_raw & clk_run;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Hang guard: the whole run needs well under this many cycles.
  always @(posedge clk_raw) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  // Wait, bounded, for core reset to let go.
  task automatic wait_run(input int lim, output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check(32'(core_reset_n), 32'h1);
  endtask : wait_run

  // Pulse the pins, check the reset state, release, await hold exit.
  task automatic enter(input logic int_boot, input logic [2:0] opt);
    int k;
    @(negedge core_clk);
    xsel_n = int_boot;
    fdone  = 1'b0;
    cfg    = {opt, 13'h1A5C};
    m.hw_pulse();
    check(32'(pad_ctl), 32'(PAD_RESET));
    check(32'(reset_out_n), 32'h0);
    check(32'(bus_strobe), 32'(STROBE_IDLE));
    m.drive(1'b1, 1'b1, 0);
    k = 0;
    while (flash_init_start !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(flash_init_start), 32'h1);
    check(32'(k), 32'(FILTER_CYC + 1));
  endtask : enter

  // After release: latched configuration, first fetch, pads running.
  task automatic finish_boot();
    int          k;
    logic [15:0] held;
    k = 0;
    while (fetch_go !== 1'b1 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    check(32'(fetch_go), 32'h1);
    check(32'(fetch_addr), 32'(BOOT_ADDR));
    check(32'(fetch_segment), 32'(BOOT_SEGMENT));
    check(32'(sys_config), 32'(cfg));
    check(32'(clock_option_pins), 32'(cfg[15:13]));
    check(32'(reset_out_n), 32'h1);
    check(32'(pad_ctl), 32'(PAD_RUN));
    held = cfg;
    cfg  = ~cfg;
    @(negedge core_clk);
    check(32'(sys_config), 32'(held));
    check(32'(bus_strobe), 32'(cstb));
  endtask : finish_boot

  task automatic rd(input logic [15:0] exp);
    @(negedge core_clk);
    frd = 1'b1;
    @(negedge core_clk);
    frd = 1'b0;
    @(negedge core_clk);
    check(32'(flash_rd_data), 32'(exp));
  endtask : rd

  // External boot under every clock option; delay differences checked.
  task automatic t_ext_boot();
    int n, n0, e;
    for (int o = 0; o < 8; o++) begin
      enter(1'b0, 3'(o));
      wait_run(300, n);
      e = ((3 + o > 8 ? 8 : 3 + o) + 1) / 2;
      if (o == 0) begin
        n0 = n;
      end
      check(32'(n - n0), 32'(e - 2));
      check(32'(n0 < 10), 32'h1);
      finish_boot();
    end
    $display("test ext_boot done");
  endtask : t_ext_boot

  // Internal boot waits for flash; early reads show the blank words.
  task automatic t_int_boot();
    int n;
    enter(1'b1, 3'h5);
    rd(FLASH_BLANK_WORD);
    repeat (20) @(negedge core_clk);
    rd(FLASH_INIT_WORD);
    repeat (40) @(negedge core_clk);
    check(32'(core_reset_n), 32'h0);
    fdone = 1'b1;
    wait_run(10, n);
    finish_boot();
    frdat = 16'h5A3C;
    rd(16'h5A3C);
    $display("test int_boot done");
  endtask : t_int_boot

  // Entry with the clock stopped, then recovery once it runs again.
  task automatic t_clockless();
    int n;
    xsel_n = 1'b0;
    @(negedge clk_raw);
    clk_run = 1'b0;
    m.clockless();
    #30;
    check(32'(reset_out_n), 32'h0);
    check(32'(core_reset_n), 32'h0);
    check(32'(pad_ctl), 32'(PAD_RESET));
    @(negedge clk_raw);
    clk_run = 1'b1;
    m.drive(1'b0, 1'b0, 10);
    m.drive(1'b1, 1'b1, 0);
    wait_run(40, n);
    $display("test clockless done");
  endtask : t_clockless

  // Warm request ignored; sense falling mid-hold goes asynchronous.
  // The two-cycle low spike first gives the filter assertion work to do.
  task automatic t_sense_fall();
    int n;
    m.drive(1'b0, 1'b1, 1);
    m.drive(1'b1, 1'b1, 2);
    check(32'(core_reset_n), 32'h1);
    m.drive(1'b0, 1'b1, 10);
    check(32'(core_reset_n), 32'h1);
    m.drive(1'b0, 1'b0, 0);
    #1;
    check(32'(reset_out_n), 32'h0);
    m.drive(1'b0, 1'b1, 20);
    check(32'(core_reset_n), 32'h0);
    check(32'(async_taken), 32'h1);
    m.drive(1'b1, 1'b1, 0);
    wait_run(40, n);
    $display("test sense_fall done");
  endtask : t_sense_fall

  // A short high spike during hold must not start the release. Sense is
  // high afterwards, so no new entry would hide a wrongly accepted spike.
  task automatic t_spike();
    int n;
    cfg = 16'h2468;
    m.hw_pulse();
    m.drive(1'b1, 1'b1, 3);
    m.drive(1'b0, 1'b1, 20);
    check(32'(sys_config), 32'(CFG_RESET));
    check(32'(core_reset_n), 32'h0);
    check(32'(async_taken), 32'h1);
    m.drive(1'b1, 1'b1, 0);
    wait_run(40, n);
    $display("test spike done");
  endtask : t_spike

  // Main sequence: reset, power-on hold, then each scenario in turn.
  initial begin
    rst_b   = 1'b0;
    clk_run = 1'b1;
    xsel_n  = 1'b0;
    fdone   = 1'b0;
    frd     = 1'b0;
    cfg     = 16'h0000;
    frdat   = 16'h0000;
    cstb    = '{1'b1, 1'b0, 1'b0};
    fails   = 0;
    n_tests = 0;
    cyc     = 0;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    m.power_on();
    t_ext_boot();
    t_int_boot();
    t_clockless();
    t_sense_fall();
    t_spike();
    print_verdict();
  end

endmodule : testbench
`default_nettype wire
